// >>> coinc_validation.sv
// Purpose: coincidence/multiplicity validation for 16 channels, apb slave
// Assumes: neighbour triggers are already on ref_clk through pins, synced here
// Notes:   one mask register pair is shown at a time through a channel index
`timescale 1ns/10ps
module coinc_validation (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	// apb slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// triggers
	input  wire logic [15:0]  fast_trig,
	input  wire logic [15:0]  right_trig,
	input  wire logic [15:0]  left_trig,
	input  wire logic [15:0]  ext_trig,
	// results
	output logic [15:0]       accept,
	output logic              delayed_local_trigger_probe,
	output logic              validation_window_probe,
	output logic              acceptance_probe,
	output logic              coincidence_or_probe
);
	typedef struct packed {
		logic [15:0][31:0]       mask_lo;
		logic [15:0][31:0]       mask_hi;
		logic [15:0]             req_val;
		coinc_pkg::outcfg_type   outcfg;
		coinc_pkg::timing_type   tim;
		logic [3:0]              selch;
		logic [15:0]             rs1, rs2, ls1, ls2, xs1, xs2;
		logic [15:0]             result;
		logic [31:0]             rdata;
		logic                    slverr;
		logic [3:0]              probes;
	} top_state_type;

	top_state_type           s_q, s_d;
	logic [15:0]             bp_trig, dly_trig, window, acc;
	logic [47:0]             all_trig;
	logic                    wr, rd, hit;
	coinc_pkg::chan_status_type st;

	assign all_trig = {s_q.ls2, s_q.rs2, bp_trig};

	// ==========================================================
	// channels
	for (genvar c = 0; c < coinc_pkg::NCH; c++) begin : g_ch
		coinc_channel u_ch (
			.ref_clk                  (ref_clk),
			.rst_n                    (rst_n),
			.tim                      (s_q.tim),
			.require_coinc_validation (s_q.req_val[c]),
			.fast_trig                (fast_trig[c]),
			.chan_result              (s_q.result[c]),
			.bp_trig                  (bp_trig[c]),
			.dly_trig                 (dly_trig[c]),
			.window                   (window[c]),
			.accept                   (acc[c])
		);
	end

	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;

	always_comb begin
		logic [47:0] m;
		logic [31:0] hi;
		logic [4:0]  nl, nr, nf;
		logic [5:0]  tot;
		logic        coinc, mult;
		m = 48'h0000_0000_0000;
		hi = 32'h0000_0000;
		nl = 5'h00;
		nr = 5'h00;
		nf = 5'h00;
		tot = 6'h00;
		coinc = 1'b0;
		mult = 1'b0;
		hit = 1'b1;
		s_d = s_q;
		// pins from neighbour modules cross in through two flops
		s_d.rs1 = right_trig;
		s_d.rs2 = s_q.rs1;
		s_d.ls1 = left_trig;
		s_d.ls2 = s_q.ls1;
		s_d.xs1 = ext_trig;
		s_d.xs2 = s_q.xs1;
		// ======================================================
		// central coincidence, one result per channel
		for (int c = 0; c < coinc_pkg::NCH; c++) begin
			hi = s_q.mask_hi[c];
			m  = all_trig & {hi[15:0], s_q.mask_lo[c]};
			nl = coinc_pkg::popcnt16(m[15:0]);
			nr = coinc_pkg::popcnt16(m[31:16]);
			nf = coinc_pkg::popcnt16(m[47:32]);
			coinc = (nl >= {2'b00, hi[coinc_pkg::B_GTH_LOC +: 3]})
				& (nr >= {2'b00, hi[coinc_pkg::B_GTH_RGT +: 3]})
				& (nf >= {2'b00, hi[coinc_pkg::B_GTH_LFT +: 3]});
			tot  = {1'b0, nl} + {1'b0, nr} + {1'b0, nf};
			mult = tot >= {1'b0, hi[coinc_pkg::B_MTH_LO +: 5]};
			if (hi[coinc_pkg::B_SRC_EXT]) begin
				s_d.result[c] = s_q.xs2[c];
			end else if (hi[coinc_pkg::B_SRC_MULT]) begin
				s_d.result[c] = mult;
			end else begin
				s_d.result[c] = coinc;
			end
		end
		// ======================================================
		// registers
		st = '{accept: acc, window: window, dly_trig: dly_trig,
			result: s_q.result};
		s_d.slverr = 1'b0;
		unique case (paddr)
			coinc_pkg::A_CTRL: begin
				if (wr) s_d.req_val = pwdata[15:0];
				s_d.rdata = {16'h0000, s_q.req_val};
			end
			coinc_pkg::A_OUTCFG: begin
				if (wr) begin
					s_d.outcfg.en = pwdata[coinc_pkg::B_OUT_EN];
					s_d.outcfg.ch = pwdata[coinc_pkg::B_PROBE_CH +: 4];
					s_d.outcfg.or_probe = pwdata[coinc_pkg::B_OR_FO6];
				end
				s_d.rdata = coinc_pkg::ZERO32;
				s_d.rdata[coinc_pkg::B_OUT_EN] = s_q.outcfg.en;
				s_d.rdata[coinc_pkg::B_PROBE_CH +: 4] = s_q.outcfg.ch;
				s_d.rdata[coinc_pkg::B_OR_FO6] = s_q.outcfg.or_probe;
			end
			coinc_pkg::A_TIMING: begin
				if (wr) s_d.tim = pwdata;
				s_d.rdata = s_q.tim;
			end
			coinc_pkg::A_STATUS: begin
				s_d.rdata = {st.window, st.result};
			end
			coinc_pkg::A_SELCH: begin
				if (wr) s_d.selch = pwdata[3:0];
				s_d.rdata = {28'h0000000, s_q.selch};
			end
			coinc_pkg::A_MASK_LO: begin
				if (wr) s_d.mask_lo[s_q.selch] = pwdata;
				s_d.rdata = s_q.mask_lo[s_q.selch];
			end
			coinc_pkg::A_MASK_HI: begin
				if (wr) s_d.mask_hi[s_q.selch] = pwdata;
				s_d.rdata = s_q.mask_hi[s_q.selch];
			end
			default: begin
				hit = 1'b0;
				s_d.rdata = coinc_pkg::ZERO32;
				s_d.slverr = psel & ~penable;
			end
		endcase
		if (!(psel & ~penable)) begin
			s_d.rdata = s_q.rdata;
			s_d.slverr = s_q.slverr;
		end
		// refused reads return zero, never stale data of an earlier read
		if (rd && !hit) s_d.rdata = coinc_pkg::ZERO32;
		// ======================================================
		// probes, registered; held low when outputs disabled
		s_d.probes = '0;
		if (s_q.outcfg.en) begin
			s_d.probes[0] = dly_trig[s_q.outcfg.ch];
			s_d.probes[1] = window[s_q.outcfg.ch];
			s_d.probes[2] = acc[s_q.outcfg.ch];
			s_d.probes[3] = s_q.outcfg.or_probe & (|s_q.result);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// setup captures read data; access completes in one cycle
	assign pready  = 1'b1;
	assign prdata  = s_q.rdata;
	assign pslverr = s_q.slverr & psel & penable;
	assign accept  = acc;
	assign delayed_local_trigger_probe = s_q.probes[0];
	assign validation_window_probe     = s_q.probes[1];
	assign acceptance_probe            = s_q.probes[2];
	assign coincidence_or_probe        = s_q.probes[3];

endmodule : coinc_validation

// >>> coinc_pkg.sv
// Purpose: constants and carriers for the channel coincidence validation
// Assumes: 16 local channels, 48 contributing trigger inputs
// Notes:   registers sit on an apb slave, one aligned word each
// Function
// - control bit n (15..0) set: channel n accepts pulse only with coincidence validation
// - 48-bit mask: local 15..0, right 31..16, left 47..32
// - upper mask bit 16 picks multiplicity (1) or coincidence (0)
// - upper mask bits 21..17 hold 5-bit multiplicity threshold
// - 3-bit group thresholds at 24..22, 27..25 and 30..28
// - upper mask bit 31 picks group/external trigger over local result
// - coincidence result opens window of programmed stretch length
// - fast trigger toward logic stretched to programmed backplane length
// - local trigger delayed by programmed external delay length
// - backplane trigger delayed by programmable amount, default 0
// - output config bit 15 enables outputs; nibble picks probed channel
// - OR of all channel coincidence results driven on fourth probe
// - every incoming fast trigger gated by the channel's own mask
// - masked triggers combined by AND and summation, result returned
// - with validation, accept only delayed trigger inside open window
package coinc_pkg;

	// ==========================================================
	// geometry
	localparam int NCH      = 16;
	localparam int NIN      = 48;
	localparam int CW_BITS  = 8;
	localparam int DLY_MAX  = 256;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] A_CTRL    = 8'h00;
	localparam logic [7:0] A_OUTCFG  = 8'h04;
	localparam logic [7:0] A_TIMING  = 8'h08;
	localparam logic [7:0] A_STATUS  = 8'h0C;
	localparam logic [7:0] A_SELCH   = 8'h10;
	localparam logic [7:0] A_MASK_LO = 8'h14;
	localparam logic [7:0] A_MASK_HI = 8'h18;

	// ==========================================================
	// fields
	localparam int B_REQ_VAL   = 13;
	localparam int B_SRC_MULT  = 16;
	localparam int B_MTH_LO    = 17;
	localparam int B_GTH_LOC   = 22;
	localparam int B_GTH_RGT   = 25;
	localparam int B_GTH_LFT   = 28;
	localparam int B_SRC_EXT   = 31;
	localparam int B_OUT_EN    = 15;
	localparam int B_PROBE_CH  = 16;
	localparam int B_OR_FO6    = 23;
	localparam int B_BP_DLY    = 0;
	localparam int B_BP_LEN    = 8;
	localparam int B_CH_STR    = 16;
	localparam int B_EXT_DLY   = 24;

	localparam logic [31:0] ZERO32 = 32'h0000_0000;

	typedef struct packed {
		logic [NCH-1:0] accept;
		logic [NCH-1:0] window;
		logic [NCH-1:0] dly_trig;
		logic [NCH-1:0] result;
	} chan_status_type;

	typedef struct packed {
		logic       en;
		logic       or_probe;
		logic [3:0] ch;
	} outcfg_type;

	typedef struct packed {
		logic [CW_BITS-1:0] ext_dly;
		logic [CW_BITS-1:0] ch_stretch;
		logic [CW_BITS-1:0] bp_len;
		logic [CW_BITS-1:0] bp_dly;
	} timing_type;

	// counts ones in a 16-bit group
	function automatic logic [4:0] popcnt16(input logic [15:0] v);
		logic [4:0] n;
		n = 5'h00;
		for (int i = 0; i < 16; i++) begin
			n = n + {4'h0, v[i]};
		end
		return n;
	endfunction : popcnt16

endpackage : coinc_pkg

// >>> coinc_channel.sv
// Purpose: one channel: trigger shaping, validation window and acceptance
// Assumes: triggers arrive as single-cycle pulses on ref_clk
// Notes:   delay lines are tap-selected shift registers
`timescale 1ns/10ps
module coinc_channel (
	// clock and reset
	input  wire logic                         ref_clk,
	input  wire logic                         rst_n,
	// configuration
	input  wire coinc_pkg::timing_type        tim,
	input  wire logic                         require_coinc_validation,
	// triggers
	input  wire logic                         fast_trig,
	input  wire logic                         chan_result,
	output logic                              bp_trig,
	output logic                              dly_trig,
	output logic                              window,
	output logic                              accept
);
	typedef struct packed {
		logic [coinc_pkg::DLY_MAX-1:0] bp_line;
		logic [coinc_pkg::DLY_MAX-1:0] ext_line;
		logic [coinc_pkg::CW_BITS-1:0] bp_cnt;
		logic [coinc_pkg::CW_BITS-1:0] win_cnt;
		logic                          acc;
		logic                          dly;
	} ch_state_type;

	ch_state_type s_q, s_d;
	logic         bp_tap, ext_tap;

	// ==========================================================
	// shaping
	always_comb begin
		bp_tap  = (tim.bp_dly == '0) ? fast_trig : s_q.bp_line[tim.bp_dly - 1'b1];
		ext_tap = (tim.ext_dly == '0) ? fast_trig : s_q.ext_line[tim.ext_dly - 1'b1];
		s_d          = s_q;
		s_d.bp_line  = {s_q.bp_line[coinc_pkg::DLY_MAX-2:0], fast_trig};
		s_d.ext_line = {s_q.ext_line[coinc_pkg::DLY_MAX-2:0], fast_trig};
		if (bp_tap) begin
			s_d.bp_cnt = tim.bp_len;
		end else if (s_q.bp_cnt != '0) begin
			s_d.bp_cnt = s_q.bp_cnt - 1'b1;
		end
		if (chan_result) begin
			s_d.win_cnt = tim.ch_stretch;
		end else if (s_q.win_cnt != '0) begin
			s_d.win_cnt = s_q.win_cnt - 1'b1;
		end
		s_d.acc = ext_tap & (~require_coinc_validation | (s_q.win_cnt != '0));
		// probe shows the trigger after the external delay, aligned with acc
		s_d.dly = ext_tap;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign bp_trig  = s_q.bp_cnt != '0;
	assign dly_trig = s_q.dly;
	assign window   = s_q.win_cnt != '0;
	assign accept   = s_q.acc;

endmodule : coinc_channel

// >>> coinc_validation_assertions.sv
// Purpose: port checker for coinc_validation
// Assumes: register reset values are zero
// Notes:   control and output config registers are shadowed from apb writes
`timescale 1ns/10ps
module coinc_validation_assertions (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// probes
	input wire logic        delayed_local_trigger_probe,
	input wire logic        validation_window_probe,
	input wire logic        acceptance_probe,
	input wire logic        coincidence_or_probe
);
	// ==========================================================
	// shadow registers
	logic [15:0] ctrl_q;
	logic [31:0] ocfg_q;
	logic        bad;
	assign bad = paddr[1:0] != 2'h0 || paddr > coinc_pkg::A_MASK_HI;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= 16'h0000;
			ocfg_q <= 32'h0000_0000;
		end else if (psel && penable && pwrite && !bad) begin
			if (paddr == coinc_pkg::A_CTRL) begin
				ctrl_q <= pwdata[15:0];
			end
			if (paddr == coinc_pkg::A_OUTCFG) begin
				ocfg_q <= pwdata & 32'h008F_8000;
			end
		end
	end
	// ==========================================================
	// properties
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_acc;
		psel && penable;
	endsequence
	sequence s_rd(logic [7:0] a);
		psel && penable && !pwrite && paddr == a;
	endsequence
	chk_ready_high: assert property (s_acc |-> pready)
		else $error("pready low in access");
	chk_err_unmapped: assert property (s_acc ##0 bad |-> pslverr)
		else $error("unmapped access not refused");
	chk_err_mapped: assert property (s_acc ##0 !bad |-> !pslverr)
		else $error("mapped access refused");
	chk_err_data: assert property (s_acc ##0 bad |-> prdata == 32'h0)
		else $error("refused read data not zero");
	chk_ctrl_back: assert property (
		s_rd(coinc_pkg::A_CTRL) |-> prdata[15:0] == ctrl_q)
		else $error("control readback wrong");
	chk_ocfg_back: assert property (
		s_rd(coinc_pkg::A_OUTCFG) |-> (prdata & 32'h008F_8000) == ocfg_q)
		else $error("output config readback wrong");
	chk_probe_off: assert property (
		!ocfg_q[15] && $past(!ocfg_q[15]) |-> !(delayed_local_trigger_probe
		|| validation_window_probe || acceptance_probe
		|| coincidence_or_probe))
		else $error("probe active while outputs off");
	chk_or_probe_src: assert property (
		coincidence_or_probe |-> $past(ocfg_q[15] && ocfg_q[23]))
		else $error("or probe without its enable");
endmodule : coinc_validation_assertions

bind coinc_validation coinc_validation_assertions u_chk (.*);

// >>> nbr_model.sv
// Purpose: neighbour modules and external trigger source
// Assumes: one request gives one single-cycle pattern
// Notes:   trigger pins are driven low between pulses
`timescale 1ns/10ps
module nbr_model (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// request
	input  wire logic        go,
	input  wire logic [47:0] pat,
	// trigger pins
	output logic      [15:0] right_trig,
	output logic      [15:0] left_trig,
	output logic      [15:0] ext_trig
);
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			{ext_trig, left_trig, right_trig} <= 48'h0;
		end else begin
			{ext_trig, left_trig, right_trig} <= go ? pat : 48'h0;
		end
	end
endmodule : nbr_model

// >>> coinc_validation_tb.sv
// Purpose: self-checking bench for coinc_validation
// Assumes: masks set for channel 0; probes on channel 0, once on channel 1
// Notes:   latencies judged inside a bounded window only
`timescale 1ns/10ps
module coinc_validation_tb;
	logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, go;
	logic        p0, p1, p2, p3, er;
	logic [2:0]  pseen;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] fast_trig, right_trig, left_trig, ext_trig, accept;
	logic [47:0] pat;
	int          err_count = 0;
	int          checked = 0;

	coinc_validation u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fast_trig(fast_trig), .right_trig(right_trig),
		.left_trig(left_trig), .ext_trig(ext_trig), .accept(accept),
		.delayed_local_trigger_probe(p0), .validation_window_probe(p1),
		.acceptance_probe(p2), .coincidence_or_probe(p3));
	nbr_model u_nbr (.ref_clk(ref_clk), .rst_n(rst_n), .go(go), .pat(pat),
		.right_trig(right_trig), .left_trig(left_trig),
		.ext_trig(ext_trig));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic print_verdict();
		if (err_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict

	task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : cmp

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			err_count++;
			print_verdict();
		end
	endtask : apb

	task automatic cfg(input logic [31:0] lo, input logic [31:0] hi);
		apb(1'b1, coinc_pkg::A_SELCH, 32'h0);
		apb(1'b1, coinc_pkg::A_MASK_LO, lo);
		apb(1'b1, coinc_pkg::A_MASK_HI, hi);
		apb(1'b0, coinc_pkg::A_MASK_LO, 32'h0);
		cmp(rd, lo);
		apb(1'b0, coinc_pkg::A_MASK_HI, 32'h0);
		cmp(rd, hi);
	endtask : cfg

	// bit 0 accept of channel 0, bit 1 or probe, seen within the window
	task automatic fire(input logic [15:0] f, input logic [47:0] p,
		input logic [1:0] exp);
		logic [1:0] seen;
		seen = 2'h0;
		pseen = 3'h0;
		@(posedge ref_clk);
		fast_trig <= f;
		pat <= p;
		go <= 1'b1;
		@(posedge ref_clk);
		fast_trig <= 16'h0;
		go <= 1'b0;
		// sampled on the falling edge, where registered outputs are settled
		repeat (60) begin
			@(negedge ref_clk);
			seen = seen | {p3, accept[0]};
			pseen = pseen | {p2, p1, p0};
		end
		cmp({30'h0, seen}, {30'h0, exp});
	endtask : fire

	task automatic t_regs();
		apb(1'b1, coinc_pkg::A_TIMING, 32'h060C_0400);
		apb(1'b0, coinc_pkg::A_TIMING, 32'h0);
		cmp(rd, 32'h060C_0400);
		apb(1'b1, coinc_pkg::A_CTRL, 32'h0000_0001);
		apb(1'b0, coinc_pkg::A_CTRL, 32'h0);
		cmp(rd, 32'h0000_0001);
		apb(1'b0, 8'h1C, 32'h0);
		cmp(rd, 32'h0000_0000);
		cmp({31'h0, er}, 32'h0000_0001);
	endtask : t_regs

	task automatic t_groups();
		cfg(32'h0000_FFFF, 32'h0080_0000);
		fire(16'h0003, 48'h0, 2'h1);
		fire(16'h0001, 48'h0, 2'h0);
		cfg(32'h0001_0000, 32'h0200_0000);
		fire(16'h0001, 48'h1, 2'h1);
		fire(16'h0001, 48'h0, 2'h0);
		cfg(32'h0000_0000, 32'h1000_0001);
		fire(16'h0001, 48'h0000_0001_0000, 2'h1);
	endtask : t_groups

	task automatic t_sources();
		cfg(32'h0000_FFFF, 32'h0005_0000);
		fire(16'h0003, 48'h0, 2'h1);
		fire(16'h0001, 48'h0, 2'h0);
		cfg(32'h0000_0000, 32'h8000_0000);
		fire(16'h0001, 48'h0001_0000_0000, 2'h1);
		fire(16'h0001, 48'h0, 2'h0);
	endtask : t_sources

	task automatic t_late_and_free();
		cfg(32'h0000_FFFF, 32'h0080_0000);
		apb(1'b1, coinc_pkg::A_TIMING, 32'h2004_0400);
		fire(16'h0003, 48'h0, 2'h0);
		apb(1'b1, coinc_pkg::A_TIMING, 32'h060C_0400);
		apb(1'b1, coinc_pkg::A_CTRL, 32'h0000_0000);
		fire(16'h0001, 48'h0, 2'h1);
		apb(1'b1, coinc_pkg::A_CTRL, 32'h0000_0001);
	endtask : t_late_and_free

	task automatic t_probe();
		// channels 1..15 keep zero thresholds, so their results stay high
		apb(1'b1, coinc_pkg::A_OUTCFG, 32'h0080_8000);
		fire(16'h0003, 48'h0, 2'h3);
		cmp({29'h0, pseen}, 32'h0000_0007);
		apb(1'b1, coinc_pkg::A_OUTCFG, 32'h0001_8000);
		fire(16'h0001, 48'h0, 2'h0);
		cmp({29'h0, pseen}, 32'h0000_0002);
		apb(1'b1, coinc_pkg::A_OUTCFG, 32'h0080_0000);
		fire(16'h0003, 48'h0, 2'h1);
		cmp({29'h0, pseen}, 32'h0000_0000);
	endtask : t_probe

	initial begin
		{psel, penable, pwrite, go} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		fast_trig = 16'h0;
		pat = 48'h0;
		rst_n = 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_regs();
		t_groups();
		t_sources();
		t_late_and_free();
		t_probe();
		print_verdict();
	end
endmodule : coinc_validation_tb
